// >>> rtl/fpsop_array.sv
// fpsop_array: fuse-programmed AND-OR array with registered or combinatorial
// output cells, fuse map and test preload reached over AHB-Lite.
// assumes: board pins (inputs, register clock, output enable) are
// asynchronous to hclk; pin drivers resolve io_out/io_oe outside.

module fpsop_array (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // board-side pins
    input wire logic [fpsop_pkg::N_DED-1:0] ded_in,
    input wire logic reg_clk,
    input wire logic reg_oe_n,
    // output pins, three signals each
    input wire logic [fpsop_pkg::N_CELL-1:0] io_in,
    output logic [fpsop_pkg::N_CELL-1:0] io_out,
    output logic [fpsop_pkg::N_CELL-1:0] io_oe
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [fpsop_pkg::N_DED-1:0] ded_s;
    logic [fpsop_pkg::N_CELL-1:0] io_s;
    logic clk_s;
    logic oe_n_s;

    fpsop_sync #(.W(fpsop_pkg::N_DED), .INIT('0)) u_sync_ded (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(ded_in),
        .q(ded_s)
    );

    fpsop_sync #(.W(fpsop_pkg::N_CELL), .INIT('0)) u_sync_io (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(io_in),
        .q(io_s)
    );

    // enable pin resets to "disabled" so nothing drives before the pin is seen;
    // clock stage resets high like its edge detector, so reset makes no edge
    fpsop_sync #(.W(2), .INIT(2'h3)) u_sync_ctl (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({reg_oe_n, reg_clk}),
        .q({oe_n_s, clk_s})
    );

    // ---------------------------------------------------------------
    // ahb-lite slave: address phase capture
    // ---------------------------------------------------------------
    logic a_valid_r;
    logic a_write_r;
    logic [11:0] a_addr_r;
    logic hreadyout_r;
    logic [31:0] hrdata_r;
    logic accept;

    assign accept = hsel & htrans[1] & hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_valid_r <= 1'b0;
            a_write_r <= 1'b0;
            a_addr_r <= 12'h000;
        end else if (hready) begin
            a_valid_r <= accept;
            a_write_r <= hwrite;
            a_addr_r <= {haddr[11:2], 2'b00};
        end
    end

    // address decode of the captured data-phase address
    logic dp_fuse;
    logic dp_ctrl;
    logic dp_preload;
    logic dp_status;
    logic dp_pins;
    logic wr_fuse;
    logic wr_ctrl;
    logic wr_preload;
    logic rd_start;

    assign dp_fuse = (a_addr_r <= fpsop_pkg::ADDR_FUSE_LAST);
    assign dp_ctrl = (a_addr_r == fpsop_pkg::ADDR_CTRL);
    assign dp_preload = (a_addr_r == fpsop_pkg::ADDR_PRELOAD);
    assign dp_status = (a_addr_r == fpsop_pkg::ADDR_STATUS);
    assign dp_pins = (a_addr_r == fpsop_pkg::ADDR_PINS);
    assign wr_fuse = a_valid_r & a_write_r & dp_fuse;
    assign wr_ctrl = a_valid_r & a_write_r & dp_ctrl;
    assign wr_preload = a_valid_r & a_write_r & dp_preload;
    // reads spend one wait state so a write just ahead is already visible
    assign rd_start = a_valid_r & ~a_write_r & ~hreadyout_r;

    // ---------------------------------------------------------------
    // fuse map and control registers
    // ---------------------------------------------------------------
    logic [fpsop_pkg::FUSE_W-1:0] fuse_r [fpsop_pkg::N_PT];
    logic [2:0] ctrl_r;
    logic [5:0] fuse_idx;

    assign fuse_idx = a_addr_r[7:2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int t = 0; t < fpsop_pkg::N_PT; t++) begin
                fuse_r[t] <= fpsop_pkg::FUSE_RESET;
            end
        end else if (wr_fuse) begin
            fuse_r[fuse_idx] <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= fpsop_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= hwdata[2:0];
        end
    end

    // ---------------------------------------------------------------
    // variant decode
    // ---------------------------------------------------------------
    logic v_reg8;
    logic v_reg6;
    logic v_reg4;
    logic v_comb;
    logic v_fix;
    logic v_low;
    logic [fpsop_pkg::N_CELL-1:0] cell_reg;
    logic [fpsop_pkg::N_CELL-1:0] cell_dedout;

    assign v_reg8 = (ctrl_r == 3'(fpsop_pkg::VAR_REG8));
    assign v_reg6 = (ctrl_r == 3'(fpsop_pkg::VAR_REG6));
    assign v_reg4 = (ctrl_r == 3'(fpsop_pkg::VAR_REG4));
    assign v_comb = (ctrl_r == 3'(fpsop_pkg::VAR_COMB_LO)) |
                    (ctrl_r == 3'(fpsop_pkg::VAR_COMB_HI));
    assign v_fix = (ctrl_r == 3'(fpsop_pkg::VAR_FIX_LO)) |
                   (ctrl_r == 3'(fpsop_pkg::VAR_FIX_HI));
    // the bidirectional cells of the register variants are always active-low
    assign v_low = v_reg6 | v_reg4 |
                   (ctrl_r == 3'(fpsop_pkg::VAR_COMB_LO)) |
                   (ctrl_r == 3'(fpsop_pkg::VAR_FIX_LO));

    // registered cells sit in the middle of the pin row, widening outwards
    assign cell_reg = v_reg8 ? 8'hff :
                      v_reg6 ? 8'h7e :
                      v_reg4 ? 8'h3c : 8'h00;
    // end cells of the combinatorial variants have no pin input of their own
    assign cell_dedout = v_comb ? 8'h81 : 8'h00;

    // ---------------------------------------------------------------
    // array columns and product terms
    // ---------------------------------------------------------------
    logic [fpsop_pkg::N_CELL-1:0] q_r;
    logic [fpsop_pkg::N_CELL-1:0] col_hi;
    logic [fpsop_pkg::N_COL-1:0] cols;
    logic [fpsop_pkg::N_PT-1:0] terms;
    logic [fpsop_pkg::N_CELL-1:0] sum8;
    logic [fpsop_pkg::N_CELL-1:0] sum7;
    logic [fpsop_pkg::N_CELL-1:0] en_term;
    logic [fpsop_pkg::N_CELL-1:0] out_nxt;
    logic [fpsop_pkg::N_CELL-1:0] oe_nxt;

    genvar k;
    generate
        for (k = 0; k < fpsop_pkg::N_CELL; k++) begin : g_cell
            // feedback reads the register itself, not the pin, so a floated
            // output still steers the array
            assign col_hi[k] = cell_reg[k] ? q_r[k] :
                               cell_dedout[k] ? ded_s[fpsop_pkg::N_DED_REG + (k / 7)] :
                               io_s[k];

            // term 0 doubles as the enable term of a seven-term cell
            assign sum8[k] = |terms[k*fpsop_pkg::N_TERM +: fpsop_pkg::N_TERM];
            assign sum7[k] = |terms[k*fpsop_pkg::N_TERM+1 +: fpsop_pkg::N_TERM-1];
            assign en_term[k] = terms[k*fpsop_pkg::N_TERM];

            assign out_nxt[k] = cell_reg[k] ? ~q_r[k] :
                                v_fix ? (sum8[k] ^ v_low) :
                                (sum7[k] ^ v_low);
            assign oe_nxt[k] = cell_reg[k] ? ~oe_n_s :
                               v_fix ? 1'b1 :
                               en_term[k];
        end
    endgenerate

    assign cols = {col_hi, ded_s[fpsop_pkg::N_DED_REG-1:0]};

    genvar t;
    generate
        for (t = 0; t < fpsop_pkg::N_PT; t++) begin : g_term
            fpsop_term u_term (
                .col(cols),
                .fuse(fuse_r[t]),
                .term(terms[t])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // output registers: board clock edge and test preload
    // ---------------------------------------------------------------
    logic clk_d_r;
    logic clk_rise;

    assign clk_rise = clk_s & ~clk_d_r;

    // starts high so a clock pin already high at reset gives no false edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_d_r <= 1'b1;
        end else begin
            clk_d_r <= clk_s;
        end
    end

    // preload beats a coinciding clock edge: a test wants the state it wrote
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_r <= fpsop_pkg::Q_RESET;
        end else if (wr_preload) begin
            q_r <= hwdata[fpsop_pkg::N_CELL-1:0];
        end else if (clk_rise) begin
            q_r <= sum8;
        end
    end

    // pin drivers follow the array one hclk later
    logic [fpsop_pkg::N_CELL-1:0] io_out_r;
    logic [fpsop_pkg::N_CELL-1:0] io_oe_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_out_r <= '0;
            io_oe_r <= '0;
        end else begin
            io_out_r <= out_nxt;
            io_oe_r <= oe_nxt;
        end
    end

    // ---------------------------------------------------------------
    // read data and bus response
    // ---------------------------------------------------------------
    logic [31:0] rd_mux;

    assign rd_mux =
        dp_fuse ? fuse_r[fuse_idx] :
        dp_ctrl ? {29'h0, ctrl_r} :
        dp_preload ? {24'h0, q_r} :
        dp_status ? {8'h0, io_oe_r, io_out_r, q_r} :
        dp_pins ? {12'h0, oe_n_s, clk_s, io_s, ded_s} :
        32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b1;
            hrdata_r <= 32'h00000000;
        end else begin
            hreadyout_r <= ~(accept & ~hwrite);
            if (rd_start) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = 1'b0;
    assign io_out = io_out_r;
    assign io_oe = io_oe_r;

endmodule

// >>> rtl/fpsop_pkg.sv
// fpsop_pkg: sizes, register map, reset values and variant codes of the
// fuse-programmed sum-of-products array.
// assumes: shared by the array top and its leaf modules; nothing is imported.
package fpsop_pkg;

    // array geometry
    localparam int N_COL = 16;
    localparam int N_CELL = 8;
    localparam int N_TERM = 8;
    localparam int N_PT = N_CELL * N_TERM;
    localparam int N_DED = 10;
    localparam int N_DED_REG = 8;
    localparam int FUSE_W = 2 * N_COL;

    // fuse word layout: bit 2*i keeps the true literal of column i,
    // bit 2*i+1 keeps the inverted literal
    localparam int FUSE_TRUE_POS = 0;
    localparam int FUSE_INV_POS = 1;

    // register map, byte addresses inside a 4 KiB window
    localparam logic [11:0] ADDR_FUSE_BASE = 12'h000;
    localparam logic [11:0] ADDR_FUSE_LAST = 12'h0fc;
    localparam logic [11:0] ADDR_CTRL = 12'h100;
    localparam logic [11:0] ADDR_PRELOAD = 12'h104;
    localparam logic [11:0] ADDR_STATUS = 12'h108;
    localparam logic [11:0] ADDR_PINS = 12'h10c;

    // status register field positions
    localparam int STAT_Q_POS = 0;
    localparam int STAT_OUT_POS = 8;
    localparam int STAT_OE_POS = 16;

    // pin view register field positions
    localparam int PINS_DED_POS = 0;
    localparam int PINS_IO_POS = 10;
    localparam int PINS_CLK_POS = 18;
    localparam int PINS_OEN_POS = 19;

    // reset values: an unprogrammed part keeps every fuse
    localparam logic [31:0] FUSE_RESET = 32'hffffffff;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [7:0] Q_RESET = 8'h00;

    // family variants, in control register order
    typedef enum logic [2:0] {
        VAR_REG8,
        VAR_REG6,
        VAR_REG4,
        VAR_COMB_LO,
        VAR_COMB_HI,
        VAR_FIX_LO,
        VAR_FIX_HI
    } fpsop_variant_e;

endpackage

// >>> rtl/fpsop_sync.sv
// fpsop_sync: two-flop synchroniser for a group of pin levels.
// assumes: pins are asynchronous to hclk; only the second stage is read.
module fpsop_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= INIT;
            q <= INIT;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule

// >>> rtl/fpsop_term.sv
// fpsop_term: one product term of the AND array, one fuse pair per column.
// assumes: fuse bit set means the link is intact; columns are settled levels.
module fpsop_term (
    // array columns and this term's fuse word
    input wire logic [fpsop_pkg::N_COL-1:0] col,
    input wire logic [fpsop_pkg::FUSE_W-1:0] fuse,
    // term result
    output logic term
);

    logic [fpsop_pkg::N_COL-1:0] lit;

    genvar i;
    generate
        for (i = 0; i < fpsop_pkg::N_COL; i++) begin : g_col
            // an intact true link demands col high, an intact inverted link
            // demands col low; both intact can never pass, both blown always do
            assign lit[i] =
                (~fuse[2*i+fpsop_pkg::FUSE_TRUE_POS] | col[i]) &
                (~fuse[2*i+fpsop_pkg::FUSE_INV_POS] | ~col[i]);
        end
    endgenerate

    assign term = &lit;

endmodule

// >>> verif/fpsop_array_monitor.sv
// fpsop_array_monitor: port-level checks of the sum-of-products array.
// assumes: one hclk domain; sees only the array top's ports.
module fpsop_array_monitor (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // pins
    input wire logic reg_clk,
    input wire logic reg_oe_n,
    input wire logic [7:0] io_out,
    input wire logic [7:0] io_oe
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic taken = hsel && htrans[1] && hready;
    logic wr_r;
    logic [11:0] addr_r;
    logic [2:0] var_r;
    logic [3:0] settle_r;
    logic [3:0] quiet_r;
    logic clk_d_r;
    // shadow of the variant so pin checks know which cell kind is live
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_r <= 1'b0;
            addr_r <= 12'h000;
            var_r <= 3'h0;
            settle_r <= 4'h0;
            quiet_r <= 4'h0;
            clk_d_r <= 1'b0;
        end else begin
            wr_r <= taken && hwrite;
            addr_r <= haddr[11:0];
            clk_d_r <= reg_clk;
            if (wr_r && addr_r == fpsop_pkg::ADDR_CTRL) begin
                var_r <= hwdata[2:0];
                settle_r <= 4'h0;
            end else if (settle_r != 4'hf) begin
                settle_r <= settle_r + 4'h1;
            end
            if (wr_r || (reg_clk && !clk_d_r)) begin
                quiet_r <= 4'h0;
            end else if (quiet_r != 4'hf) begin
                quiet_r <= quiet_r + 4'h1;
            end
        end
    end
    AST_READ_WAIT: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase is not one wait state");
    AST_WRITE_NOWAIT: assert property (taken && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("error response seen");
    AST_RDATA_HOLD: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved outside a read");
    AST_FIXED_DRIVE:
        assert property (var_r inside {3'h5, 3'h6} && settle_r > 4'h4 |-> io_oe == 8'hff)
        else $error("enable-free cells not driven");
    AST_OE_ON:
        assert property (var_r == 3'h0 && settle_r > 4'h4 && $fell(reg_oe_n)
            |-> ##[1:4] io_oe == 8'hff)
        else $error("registered cells not enabled by the pin");
    AST_OE_OFF:
        assert property (var_r == 3'h0 && settle_r > 4'h4 && $rose(reg_oe_n)
            |-> ##[1:4] io_oe == 8'h00)
        else $error("registered cells not floated by the pin");
    AST_REG_QUIET:
        assert property (var_r == 3'h0 && settle_r > 4'h7 && quiet_r > 4'h7 |-> $stable(io_out))
        else $error("registered outputs moved without a clock edge");
endmodule

bind fpsop_array fpsop_array_monitor fpsop_array_monitor_inst (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .reg_clk,
    .reg_oe_n, .io_out, .io_oe);

// >>> verif/fpsop_board.sv
// fpsop_board: board logic around the array: inputs, register clock, enable.
// assumes: undriven output pins are pulled high on the board.
module fpsop_board (
    // clock
    input wire logic hclk,
    // drives to the array
    output logic [9:0] ded_in,
    output logic reg_clk,
    output logic reg_oe_n,
    // pin levels
    input wire logic [7:0] io_out,
    input wire logic [7:0] io_oe,
    output logic [7:0] io_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ded_in = 10'h000;
        reg_clk = 1'b0;
        reg_oe_n = 1'b1;
    end
    assign io_in = (io_out & io_oe) | ~io_oe;
    task automatic set_ded(input logic [9:0] v);
        @(posedge hclk);
        ded_in <= v;
    endtask
    task automatic set_oe_n(input logic v);
        @(posedge hclk);
        reg_oe_n <= v;
    endtask
    // both phases last well past the array's two-flop pin sampling
    task automatic pulse_clk();
        @(posedge hclk);
        reg_clk <= 1'b1;
        repeat (4) @(posedge hclk);
        reg_clk <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask
endmodule

// >>> verif/fpsop_array_tb.sv
// fpsop_array_tb: self-checking bench for the sum-of-products array.
// assumes: this bench is the only bus master; board model in fpsop_board.
module fpsop_array_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [9:0] ded_in;
    logic reg_clk;
    logic reg_oe_n;
    logic [7:0] io_in;
    logic [7:0] io_out;
    logic [7:0] io_oe;
    logic [31:0] rd;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [11:0] fa [6] = '{12'h000, 12'h020, 12'h040, 12'h060, 12'h080, 12'h09c};
    logic [31:0] fv [6] = '{32'h1, 32'h0, 32'h2, 32'h00800000, 32'h1, 32'h4};
    logic [7:0] oe_tab [8] = '{8'h00, 8'h01, 8'h03, 8'h1b, 8'h1b, 8'hff, 8'hff, 8'h1b};
    logic [7:0] drv_tab [8] = '{8'h00, 8'h01, 8'h03, 8'h1b, 8'h00, 8'he4, 8'h1b, 8'h00};

    fpsop_array fpsop_array_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ded_in,
        .reg_clk, .reg_oe_n, .io_in, .io_out, .io_oe);
    fpsop_board fpsop_board_inst (.hclk, .ded_in, .reg_clk, .reg_oe_n, .io_out, .io_oe,
        .io_in);

    initial begin
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // address phase held until hready, then data phase until hready again
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic t_reset();
        rdchk("fuse first", 12'h000, fpsop_pkg::FUSE_RESET);
        rdchk("fuse last", fpsop_pkg::ADDR_FUSE_LAST, fpsop_pkg::FUSE_RESET);
        rdchk("ctrl", fpsop_pkg::ADDR_CTRL, 32'h0);
        rdchk("unmapped", 12'h200, 32'h0);
        chk("oe at reset", 32'h0, {24'h0, io_oe});
    endtask
    task automatic t_program();
        for (int i = 0; i < 6; i++) begin
            wr(fa[i], fv[i]);
            rdchk("fuse", fa[i], fv[i]);
        end
    endtask
    // true, inverted, false, true-by-blowing, OR of two terms, inverted feedback
    task automatic t_registered();
        fpsop_board_inst.set_ded(10'h002);
        wr(fpsop_pkg::ADDR_PRELOAD, 32'h0);
        rdchk("preload", fpsop_pkg::ADDR_PRELOAD, 32'h0);
        fpsop_board_inst.pulse_clk();
        rdchk("q", fpsop_pkg::ADDR_PRELOAD, 32'h1e);
        chk("io_out", 32'he1, {24'h0, io_out});
        wr(fpsop_pkg::ADDR_PRELOAD, 32'h08);
        fpsop_board_inst.pulse_clk();
        rdchk("q", fpsop_pkg::ADDR_PRELOAD, 32'h16);
    endtask
    task automatic t_enable();
        fpsop_board_inst.set_oe_n(1'b0);
        repeat (4) @(posedge hclk);
        chk("io_oe on", 32'hff, {24'h0, io_oe});
        rdchk("status", fpsop_pkg::ADDR_STATUS, 32'h00ffe916);
        fpsop_board_inst.pulse_clk();
        rdchk("q", fpsop_pkg::ADDR_PRELOAD, 32'h1e);
        fpsop_board_inst.set_oe_n(1'b1);
        repeat (4) @(posedge hclk);
        chk("io_oe off", 32'h0, {24'h0, io_oe});
    endtask
    task automatic t_variants();
        wr(12'h060, 32'h0);
        // column 8 only counts with column 1 high, so no bidir cell loops its
        // own pin back into its sum while the variants are swept
        wr(12'h004, 32'h00010004);
        fpsop_board_inst.set_ded(10'h001);
        for (int v = 0; v < 8; v++) begin
            wr(fpsop_pkg::ADDR_CTRL, 32'(v));
            repeat (6) @(posedge hclk);
            rdchk("ctrl", fpsop_pkg::ADDR_CTRL, 32'(v));
            chk("io_oe", {24'h0, oe_tab[v]}, {24'h0, io_oe});
            chk("drive", {24'h0, drv_tab[v]}, {24'h0, io_out & io_oe});
        end
        wr(fpsop_pkg::ADDR_CTRL, 32'h4);
        fpsop_board_inst.set_ded(10'h103);
        repeat (6) @(posedge hclk);
        chk("ded8 column", 32'h11, {24'h0, io_out & io_oe});
    endtask

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_program();
        t_registered();
        t_enable();
        t_variants();
        stop_test();
    end
endmodule
